//--- rtl/tmw_timer8.v
/*
 * 8-bit up/down timer with one compare channel and four waveform modes,
 * Avalon-MM slave with waitrequest, built-in prescaler and external tick pin.
 * Assumes clk_i is the I/O clock; ext_tick_i is async, the pin direction is registered on clk_i.
 */
`timescale 1ns/10ps
`include "tmw_timer8_regs.vh"

module tmw_timer8 #(
  parameter PRESC_W = 10
) (
  input  wire        clk_i,
  input  wire        rst_n_i,
  input  wire        clk_en_i,
  input  wire [3:0]  avs_address_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [31:0] avs_writedata_i,
  input  wire [3:0]  avs_byteenable_i,
  output reg  [31:0] avs_readdata_o,
  output wire        avs_waitrequest_o,
  input  wire        ext_tick_i,
  output wire        compare_output_o,
  output wire        compare_output_oe_o,
  output wire        pin_override_o,
  output wire        overflow_flag_o,
  output wire        compare_match_flag_o
);

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  reg  [8:0]         ctrl_r;
  reg  [7:0]         count_value_r;
  reg  [7:0]         compare_value_r;
  reg  [7:0]         compare_buf_r;
  reg                down_r;
  reg                overflow_flag_r;
  reg                compare_match_flag_r;
  reg                compare_output_r;
  reg                match_pend_r;
  reg                block_r;
  reg                ack_r;
  reg  [PRESC_W-1:0] presc_r;
  reg  [2:0]         ext_sync_r;

  wire [2:0] clock_source_sel    = ctrl_r[`TMW_CTRL_CS_MSB:`TMW_CTRL_CS_LSB];
  wire [1:0] waveform_mode_sel   = ctrl_r[`TMW_CTRL_WGM_MSB:`TMW_CTRL_WGM_LSB];
  wire [1:0] compare_output_mode = ctrl_r[`TMW_CTRL_COM_MSB:`TMW_CTRL_COM_LSB];
  wire       pwm_mode            = waveform_mode_sel[0];

  // --------------------------------------------------------------------------
  // bus decode: one wait cycle, answer on second cycle
  // --------------------------------------------------------------------------
  wire req      = avs_read_i | avs_write_i;
  wire acc      = req & ack_r;
  wire wr       = acc & avs_write_i;
  wire be0      = avs_byteenable_i[0];
  wire be1      = avs_byteenable_i[1];
  wire wr_ctrl  = wr & (avs_address_i == `TMW_ADDR_CTRL);
  wire wr_count = wr & be0 & (avs_address_i == `TMW_ADDR_COUNT);
  wire wr_cmp   = wr & be0 & (avs_address_i == `TMW_ADDR_CMP);
  wire wr_flags = wr & be0 & (avs_address_i == `TMW_ADDR_FLAGS);
  wire force_cmp = wr_ctrl & be0 & avs_writedata_i[`TMW_CTRL_FORCE] & ~pwm_mode;

  // no acceptance while frozen, else a write would be acked and lost
  assign avs_waitrequest_o = req & ~(ack_r & clk_en_i);

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_r <= 1'b0;
    end else if (clk_en_i) begin
      ack_r <= req & ~ack_r;
    end
  end

  // --------------------------------------------------------------------------
  // timer tick: prescaler or synchronised external pin
  // --------------------------------------------------------------------------
  wire ext_rise = ext_sync_r[1] & ~ext_sync_r[2];
  wire ext_fall = ~ext_sync_r[1] & ext_sync_r[2];
  reg  timer_tick;

  always @* begin
    case (clock_source_sel)
      `TMW_CS_STOP:     timer_tick = 1'b0;
      `TMW_CS_DIV1:     timer_tick = 1'b1;
      `TMW_CS_DIV8:     timer_tick = (presc_r[2:0] == 3'h7);
      `TMW_CS_DIV64:    timer_tick = (presc_r[5:0] == 6'h3F);
      `TMW_CS_DIV256:   timer_tick = (presc_r[7:0] == 8'hFF);
      `TMW_CS_DIV1024:  timer_tick = (presc_r[9:0] == 10'h3FF);
      `TMW_CS_EXT_FALL: timer_tick = ext_fall;
      `TMW_CS_EXT_RISE: timer_tick = ext_rise;
      default:          timer_tick = 1'b0;
    endcase
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      presc_r    <= {PRESC_W{1'b0}};
      ext_sync_r <= 3'h0;
    end else if (clk_en_i) begin
      presc_r    <= presc_r + {{(PRESC_W-1){1'b0}}, 1'b1};
      ext_sync_r <= {ext_sync_r[1:0], ext_tick_i};
    end
  end

  // --------------------------------------------------------------------------
  // counting sequence, depends on waveform mode and, in CTC, on the compare value
  // --------------------------------------------------------------------------
  wire at_max  = (count_value_r == `TMW_MAX);
  wire at_bot  = (count_value_r == `TMW_BOTTOM);
  wire match   = (count_value_r == compare_value_r) & ~block_r;
  reg  [7:0] count_nxt;
  reg        down_nxt;
  reg        ovf_set;

  always @* begin
    count_nxt = count_value_r + 8'h01;
    down_nxt  = down_r;
    ovf_set   = 1'b0;
    case (waveform_mode_sel)
      `TMW_WGM_NORMAL: begin
        ovf_set = at_max;
      end
      `TMW_WGM_CTC: begin
        if (count_value_r == compare_value_r) begin
          count_nxt = `TMW_BOTTOM;
        end
        ovf_set = at_max;
      end
      `TMW_WGM_FAST: begin
        ovf_set = at_max;
      end
      `TMW_WGM_PHASE: begin
        if (down_r) begin
          if (at_bot) begin
            down_nxt  = 1'b0;
            count_nxt = 8'h01;
          end else begin
            count_nxt = count_value_r - 8'h01;
          end
        end else if (at_max) begin
          down_nxt  = 1'b1;
          count_nxt = count_value_r - 8'h01;
        end
        ovf_set = down_r & (count_value_r == 8'h01);
      end
      default: begin
        ovf_set = 1'b0;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // compare output next state
  // --------------------------------------------------------------------------
  reg out_nxt;

  always @* begin
    out_nxt = compare_output_r;
    case (waveform_mode_sel)
      `TMW_WGM_NORMAL, `TMW_WGM_CTC: begin
        if (match) begin
          case (compare_output_mode)
            2'h1:    out_nxt = ~compare_output_r;
            2'h2:    out_nxt = 1'b0;
            2'h3:    out_nxt = 1'b1;
            default: out_nxt = compare_output_r;
          endcase
        end
      end
      `TMW_WGM_FAST: begin
        if (compare_output_mode == 2'h1) begin
          if (match) begin
            out_nxt = ~compare_output_r;
          end
        end else if (compare_output_mode[1]) begin
          if (at_max) begin
            out_nxt = ~compare_output_mode[0];
          end else if (match) begin
            out_nxt = compare_output_mode[0];
          end
        end
      end
      `TMW_WGM_PHASE: begin
        if (compare_output_mode[1]) begin
          if (compare_value_r == `TMW_MAX && at_max) begin
            out_nxt = ~compare_output_mode[0];
          end else if (match && !(down_r && at_bot) && !at_max) begin
            out_nxt = down_nxt ? ~compare_output_mode[0] : compare_output_mode[0];
          end else if (down_r && at_bot) begin
            out_nxt = compare_value_r == `TMW_BOTTOM ? compare_output_mode[0]
                                                     : ~compare_output_mode[0];
          end
        end
      end
      default: begin
        out_nxt = compare_output_r;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // counter, compare, flags
  // --------------------------------------------------------------------------
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_r               <= `TMW_RST_CTRL;
      count_value_r        <= `TMW_RST_BYTE;
      compare_value_r      <= `TMW_RST_BYTE;
      compare_buf_r        <= `TMW_RST_BYTE;
      down_r               <= 1'b0;
      overflow_flag_r      <= 1'b0;
      compare_match_flag_r <= 1'b0;
      compare_output_r     <= 1'b0;
      match_pend_r         <= 1'b0;
      block_r              <= 1'b0;
    end else if (clk_en_i) begin
      if (wr_ctrl && be0) begin
        ctrl_r[7:0] <= {1'b0, avs_writedata_i[6:0]};
      end
      if (wr_ctrl && be1) begin
        ctrl_r[`TMW_CTRL_DIR] <= avs_writedata_i[`TMW_CTRL_DIR];
      end
      if (wr_cmp) begin
        compare_buf_r <= avs_writedata_i[7:0];
        if (!pwm_mode) begin
          compare_value_r <= avs_writedata_i[7:0];
        end
      end
      if (wr_count) begin
        block_r <= 1'b1;
      end else if (timer_tick) begin
        block_r <= 1'b0;
      end
      if (wr_count) begin
        count_value_r <= avs_writedata_i[7:0];
      end else if (timer_tick) begin
        count_value_r <= count_nxt;
        down_r        <= down_nxt;
      end
      if (timer_tick) begin
        match_pend_r <= match;
        if (waveform_mode_sel == `TMW_WGM_PHASE && at_max && !down_r) begin
          compare_value_r <= compare_buf_r;
        end else if (waveform_mode_sel == `TMW_WGM_FAST && at_max) begin
          compare_value_r <= compare_buf_r;
        end
      end
      if (force_cmp) begin
        case (compare_output_mode)
          2'h1:    compare_output_r <= ~compare_output_r;
          2'h2:    compare_output_r <= 1'b0;
          2'h3:    compare_output_r <= 1'b1;
          default: compare_output_r <= compare_output_r;
        endcase
      end else if (timer_tick) begin
        compare_output_r <= out_nxt;
      end
      if (timer_tick && ovf_set) begin
        overflow_flag_r <= 1'b1;
      end else if (wr_flags && avs_writedata_i[`TMW_FLAG_OVF]) begin
        overflow_flag_r <= 1'b0;
      end
      if (timer_tick && match_pend_r) begin
        compare_match_flag_r <= 1'b1;
      end else if (wr_flags && avs_writedata_i[`TMW_FLAG_CMP]) begin
        compare_match_flag_r <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // read data and pin
  // --------------------------------------------------------------------------
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (clk_en_i) begin
      // latched in the wait cycle so it stands at the accepting edge
      if (avs_read_i && !ack_r) begin
        case (avs_address_i)
          `TMW_ADDR_CTRL:  avs_readdata_o <= {23'h0, ctrl_r};
          `TMW_ADDR_COUNT: avs_readdata_o <= {24'h0, count_value_r};
          `TMW_ADDR_CMP:   avs_readdata_o <= {24'h0, pwm_mode ? compare_buf_r : compare_value_r};
          `TMW_ADDR_FLAGS: avs_readdata_o <= {29'h0, compare_output_r, compare_match_flag_r, overflow_flag_r};
          default:         avs_readdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign pin_override_o       = |compare_output_mode;
  assign compare_output_o     = compare_output_r;
  assign compare_output_oe_o  = ctrl_r[`TMW_CTRL_DIR];
  assign overflow_flag_o      = overflow_flag_r;
  assign compare_match_flag_o = compare_match_flag_r;

endmodule // tmw_timer8

//--- rtl/tmw_timer8_regs.vh
/*
 * Register map, field positions, reset values and mode codes of the 8-bit
 * waveform timer. Assumes inclusion by bare name from the timer module.
 */
// How it works
// - normal mode counts up, wraps FF to 00
// - normal overflow flag set when count becomes zero
// - counting only sets flags, software clears
// - clear-on-compare clears counter after compare match
// - compare below count wraps through FF first
// - clear-on-compare mode 1 toggles output per match
// - clear-on-compare overflow flag on FF to 00
// - fast PWM counts 00 to FF, single slope
// - fast PWM 2 clear-match set-bottom, 3 inverse
// - fast PWM overflow flag at maximum
// - fast PWM period is 256 ticks
// - fast PWM extremes: spike or constant level
// - fast PWM mode 1 toggles, compare buffered
// - phase-correct up/down, holds maximum one tick
// - phase-correct 2 clear-up set-down, 3 inverse
// - phase-correct overflow flag at zero
// - phase-correct period is 510 ticks
// - phase-correct extremes give constant levels
// - phase-correct symmetry transition at bottom
// - waveform mode and, in CTC, compare value shape counting sequence
// - output drives pin only when direction output
// - clock select zero stops counter, access kept
// - compare flag set tick after match
// - PWM compare buffered, loaded at extreme
`ifndef TMW_TIMER8_REGS_VH
`define TMW_TIMER8_REGS_VH

// ----------------------------------------------------------------------------
// register byte addresses (word index << 2)
// ----------------------------------------------------------------------------
`define TMW_ADDR_CTRL    4'h0
`define TMW_ADDR_COUNT   4'h4
`define TMW_ADDR_CMP     4'h8
`define TMW_ADDR_FLAGS   4'hC

// ----------------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------------
`define TMW_CTRL_CS_LSB   0
`define TMW_CTRL_CS_MSB   2
`define TMW_CTRL_WGM_LSB  3
`define TMW_CTRL_WGM_MSB  4
`define TMW_CTRL_COM_LSB  5
`define TMW_CTRL_COM_MSB  6
`define TMW_CTRL_FORCE    7
`define TMW_CTRL_DIR      8

// flags register fields
`define TMW_FLAG_OVF      0
`define TMW_FLAG_CMP      1
`define TMW_FLAG_OUT      2

// ----------------------------------------------------------------------------
// modes, selections and reset values
// ----------------------------------------------------------------------------
`define TMW_WGM_NORMAL    2'h0
`define TMW_WGM_PHASE     2'h1
`define TMW_WGM_CTC       2'h2
`define TMW_WGM_FAST      2'h3
`define TMW_CS_STOP       3'h0
`define TMW_CS_DIV1       3'h1
`define TMW_CS_DIV8       3'h2
`define TMW_CS_DIV64      3'h3
`define TMW_CS_DIV256     3'h4
`define TMW_CS_DIV1024    3'h5
`define TMW_CS_EXT_FALL   3'h6
`define TMW_CS_EXT_RISE   3'h7
`define TMW_MAX           8'hFF
`define TMW_BOTTOM        8'h00
`define TMW_RST_CTRL      9'h000
`define TMW_RST_BYTE      8'h00

`endif

//--- sim/tmw_timer8_chk.sv
/* checker of the timer's bus handshake, pin enable and sticky flags
   assumes: bound to tmw_timer8, one clock domain clk_i */
`timescale 1ns/10ps
module tmw_timer8_chk #(
  parameter PRESC_W = 10
) (
  input wire        clk_i,
  input wire        rst_n_i,
  input wire        clk_en_i,
  input wire [3:0]  avs_address_i,
  input wire        avs_read_i,
  input wire        avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0]  avs_byteenable_i,
  input wire [31:0] avs_readdata_o,
  input wire        avs_waitrequest_o,
  input wire        compare_output_o,
  input wire        compare_output_oe_o,
  input wire        pin_override_o,
  input wire        overflow_flag_o,
  input wire        compare_match_flag_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  wire wr_ok = avs_write_i && !avs_waitrequest_o && clk_en_i;
  wire rd_ok = avs_read_i && !avs_waitrequest_o && clk_en_i;
  wire ctl_w = wr_ok && avs_address_i == 4'h0;
  wire flg_w = wr_ok && avs_address_i == 4'hC && avs_byteenable_i[0];

  property p_wait_one; avs_waitrequest_o && clk_en_i ##1 clk_en_i |-> !avs_waitrequest_o; endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait longer than one cycle");
  property p_wait_req; avs_waitrequest_o |-> avs_read_i || avs_write_i; endproperty
  a_wait_req: assert property (p_wait_req) else $error("wait without request");
  property p_dir; ctl_w && avs_byteenable_i[1] |=> compare_output_oe_o == $past(avs_writedata_i[8]); endproperty
  a_dir: assert property (p_dir) else $error("pin enable not written");
  property p_ovr;
    ctl_w && avs_byteenable_i[0] |=> pin_override_o == ($past(avs_writedata_i[6:5]) != 2'h0);
  endproperty
  a_ovr: assert property (p_ovr) else $error("override not from output mode");
  property p_ovf_sticky; $fell(overflow_flag_o) |-> $past(flg_w && avs_writedata_i[0]); endproperty
  a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag dropped");
  property p_cmp_sticky; $fell(compare_match_flag_o) |-> $past(flg_w && avs_writedata_i[1]); endproperty
  a_cmp_sticky: assert property (p_cmp_sticky) else $error("match flag dropped");
  property p_freeze;
    !clk_en_i |=> $stable(overflow_flag_o) && $stable(compare_match_flag_o) && $stable(compare_output_o);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");
  property p_rd_hold;
    !(avs_read_i && avs_waitrequest_o && clk_en_i) |=> $stable(avs_readdata_o);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");

  c_ctl: cover property (ctl_w);
  c_ovf: cover property ($rose(overflow_flag_o));
  c_cmp: cover property ($rose(compare_match_flag_o));
  c_out: cover property ($changed(compare_output_o) && compare_output_oe_o);
endmodule // tmw_timer8_chk

bind tmw_timer8 tmw_timer8_chk #(.PRESC_W(PRESC_W)) i_tmw_timer8_chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .compare_output_o(compare_output_o),
  .compare_output_oe_o(compare_output_oe_o), .pin_override_o(pin_override_o),
  .overflow_flag_o(overflow_flag_o), .compare_match_flag_o(compare_match_flag_o));

//--- sim/tmw_port_model.sv
/* port pin with pull-down and an external event source
   assumes: tick is called from the bench's main process */
`timescale 1ns/10ps
module tmw_port_model (
  input  wire clk_i,
  input  wire compare_output_i,
  input  wire compare_output_oe_i,
  output reg  ext_tick_o,
  output wire pin_level_o
);
  // pulled low when the timer releases the pin
  assign pin_level_o = compare_output_oe_i ? compare_output_i : 1'b0;
  initial ext_tick_o = 1'b0;

  // one rising edge per event, wide enough for the synchroniser
  task tick(input integer n);
    integer k;
    begin
      for (k = 0; k < n; k = k + 1) begin
        @(posedge clk_i);
        ext_tick_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        ext_tick_o <= 1'b0;
        repeat (4) @(posedge clk_i);
      end
    end
  endtask
endmodule // tmw_port_model

//--- sim/tb.sv
/* self-checking bench of the 8-bit waveform timer
   assumes: timer counts external rising or falling edges from the port model */
`timescale 1ns/10ps
module tb;
  reg         clk_i            = 1'b0;
  reg         rst_n_i          = 1'b0;
  reg         clk_en_i         = 1'b1;
  reg  [3:0]  avs_address_i    = 4'h0;
  reg         avs_read_i       = 1'b0;
  reg         avs_write_i      = 1'b0;
  reg  [31:0] avs_writedata_i  = 32'h0;
  reg  [3:0]  avs_byteenable_i = 4'hF;
  wire [31:0] avs_readdata_o;
  wire        avs_waitrequest_o, ext_tick_w, out_w, oe_w, pin_w, ovr_w, ovf_w, cmp_w;
  integer     n_mismatch = 0;
  integer     num_checks = 0;
  integer     c;
  reg  [31:0] seed = 32'h6617;
  reg  [31:0] r;
  reg  [31:0] exp_q[$];
  reg  [31:0] msk_q[$];
  reg         acc;

  initial forever #12.5 clk_i = ~clk_i;

  tmw_timer8 i_tmw_timer8 (.clk_i(clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .ext_tick_i(ext_tick_w), .compare_output_o(out_w), .compare_output_oe_o(oe_w),
    .pin_override_o(ovr_w), .overflow_flag_o(ovf_w), .compare_match_flag_o(cmp_w));
  tmw_port_model i_tmw_port_model (.clk_i(clk_i), .compare_output_i(out_w),
    .compare_output_oe_i(oe_w), .ext_tick_o(ext_tick_w), .pin_level_o(pin_w));

  function [31:0] xs;
    begin
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      xs = seed;
    end
  endfunction

  task chk(input [31:0] seen, input [31:0] expv);
    begin
      num_checks = num_checks + 1;
      if (seen !== expv) begin
        n_mismatch = n_mismatch + 1;
        $display("mismatch t=%0t seen=%h exp=%h", $time, seen, expv);
      end
    end
  endtask

  task xfer(input w, input [3:0] a, input [8:0] d, input [3:0] be);
    reg [31:0] q;
    reg        done;
    begin
      q = xs();
      done = 1'b0;
      @(posedge clk_i);
      avs_address_i <= a;
      avs_writedata_i <= {q[31:9], d};
      avs_byteenable_i <= be;
      avs_write_i <= w;
      avs_read_i <= !w;
      // settled wait level, as the next rising edge will sample it
      while (!done) begin
        @(negedge clk_i);
        done = (avs_waitrequest_o === 1'b0);
        @(posedge clk_i);
      end
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
    end
  endtask

  task wr(input [3:0] a, input [8:0] d);
    xfer(1'b1, a, d, 4'hF);
  endtask

  task wrb(input [3:0] a, input [8:0] d, input [3:0] be);
    xfer(1'b1, a, d, be);
  endtask

  task rd(input [3:0] a, input [31:0] e, input [31:0] m);
    begin
      exp_q.push_back(e & m);
      msk_q.push_back(m);
      xfer(1'b0, a, 9'h0, 4'hF);
    end
  endtask

  task tally_and_finish;
    begin
      if (n_mismatch == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask

  // read data taken at the accepting edge, where it stands
  always @(posedge clk_i) begin
    acc = avs_read_i && !avs_waitrequest_o && clk_en_i && rst_n_i;
    if (acc === 1'b1) chk(avs_readdata_o & msk_q.pop_front(), exp_q.pop_front());
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch = n_mismatch + 1;
    tally_and_finish;
  end

  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(4'h0, 32'h0, 32'h1FF);
    rd(4'h4, 32'h0, 32'hFF);
    rd(4'h8, 32'h0, 32'hFF);
    rd(4'hC, 32'h0, 32'h7);
    rd(4'h2, 32'h0, 32'hFFFFFFFF);
    // normal mode wrap and sticky overflow
    wr(4'h4, 9'h0FE);
    wr(4'h0, 9'h007);
    i_tmw_port_model.tick(2);
    rd(4'h4, 32'h0, 32'hFF);
    rd(4'hC, 32'h1, 32'h1);
    chk({31'h0, ovf_w}, 32'h1);
    i_tmw_port_model.tick(1);
    rd(4'hC, 32'h1, 32'h1);
    wr(4'h0, 9'h000);
    wr(4'hC, 9'h003);
    rd(4'hC, 32'h0, 32'h3);
    // clear on compare with toggle
    wr(4'h8, 9'h002);
    wr(4'h4, 9'h000);
    wr(4'h0, 9'h137);
    i_tmw_port_model.tick(3);
    rd(4'h4, 32'h0, 32'hFF);
    rd(4'hC, 32'h6, 32'h7);
    chk({31'h0, cmp_w}, 32'h1);
    chk({31'h0, pin_w}, 32'h1);
    i_tmw_port_model.tick(3);
    rd(4'hC, 32'h2, 32'h7);
    wr(4'h0, 9'h057);
    @(posedge clk_i);
    #1;
    chk({31'h0, pin_w}, 32'h0);
    // compare set below the count
    wr(4'hC, 9'h003);
    wr(4'h4, 9'h005);
    wr(4'h8, 9'h003);
    i_tmw_port_model.tick(251);
    rd(4'h4, 32'h0, 32'hFF);
    rd(4'hC, 32'h3, 32'h3);
    wr(4'hC, 9'h003);
    i_tmw_port_model.tick(4);
    rd(4'h4, 32'h0, 32'hFF);
    rd(4'hC, 32'h0, 32'h3);
    i_tmw_port_model.tick(1);
    rd(4'hC, 32'h2, 32'h3);
    // fast pwm, both polarities, buffered compare
    for (c = 2; c < 4; c = c + 1) begin
      wr(4'h0, 9'h018);
      wr(4'hC, 9'h003);
      wr(4'h4, 9'h0FD);
      wr(4'h8, 9'h002);
      wr(4'h0, (c == 2) ? 9'h15F : 9'h17F);
      i_tmw_port_model.tick(3);
      rd(4'h4, 32'h0, 32'hFF);
      rd(4'hC, (c == 2) ? 32'h5 : 32'h1, 32'h7);
      i_tmw_port_model.tick(4);
      rd(4'hC, (c == 2) ? 32'h3 : 32'h7, 32'h7);
    end
    // phase correct up and down
    wr(4'h0, 9'h008);
    wr(4'hC, 9'h003);
    wr(4'h4, 9'h0FD);
    wr(4'h8, 9'h080);
    wr(4'h0, 9'h14F);
    i_tmw_port_model.tick(3);
    rd(4'h4, 32'hFE, 32'hFF);
    i_tmw_port_model.tick(254);
    rd(4'h4, 32'h0, 32'hFF);
    rd(4'hC, 32'h7, 32'h7);
    chk({31'h0, ovf_w}, 32'h1);
    i_tmw_port_model.tick(1);
    rd(4'h4, 32'h1, 32'hFF);
    // stopped counter keeps software access; forced toggle
    wr(4'h0, 9'h000);
    wr(4'h0, 9'h020);
    wr(4'h0, 9'h0A0);
    rd(4'hC, 32'h0, 32'h4);
    r = xs();
    wr(4'h4, {1'b0, r[7:0]});
    i_tmw_port_model.tick(3);
    rd(4'h4, {24'h0, r[7:0]}, 32'hFF);
    wrb(4'h4, 9'h0AA, 4'hE);
    wrb(4'h0, 9'h100, 4'h2);
    @(posedge clk_i);
    clk_en_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    clk_en_i <= 1'b1;
    chk({30'h0, ovr_w, oe_w}, 32'h3);
    rd(4'h4, {24'h0, r[7:0]}, 32'hFF);
    rd(4'h0, 32'h120, 32'h1FF);
    // falling-edge source, then a reset in mid-run
    wr(4'h4, 9'h000);
    wr(4'h0, 9'h006);
    i_tmw_port_model.tick(2);
    rd(4'h4, 32'h2, 32'hFF);
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(4'h0, 32'h0, 32'h1FF);
    rd(4'hC, 32'h0, 32'h7);
    chk({29'h0, ovr_w, ovf_w, cmp_w}, 32'h0);
    repeat (4) @(posedge clk_i);
    tally_and_finish;
  end
endmodule // tb
